// ==== hw/adcc_consts.svh ====
// Constants for the conversion controller: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package; the design modules only use its macros.
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH

`define ADCC_NCH          12
`define ADCC_AW           7
// Register byte offsets; channel data run from 0x30 up to 0x5c.
`define ADCC_OFS_CTRL     7'h00
`define ADCC_OFS_MODE     7'h04
`define ADCC_OFS_CHEN     7'h08
`define ADCC_OFS_CHDIS    7'h0c
`define ADCC_OFS_CHSTAT   7'h10
`define ADCC_OFS_TRIG     7'h14
`define ADCC_OFS_LAST     7'h18
`define ADCC_OFS_STAT     7'h1c
`define ADCC_OFS_OVR      7'h20
`define ADCC_OFS_EXT      7'h24
`define ADCC_OFS_CWIN     7'h28
`define ADCC_OFS_CDAT0    7'h30
// Control register bits.
`define ADCC_CTRL_RESET   0
`define ADCC_CTRL_START   1
// Mode register fields.
`define ADCC_MODE_LOW_RESOLUTION_BIT  4
`define ADCC_MODE_SLEEP   5
`define ADCC_MODE_PRE_LSB 8
`define ADCC_MODE_TRK_LSB 24
`define ADCC_MODE_RST     32'h0000_0000
// Status register bits.
`define ADCC_ST_DATA_READY_FLAG      24
`define ADCC_ST_GOVR      25
`define ADCC_ST_CMP       26
// Timing in converter clock cycles.
`define ADCC_HOLD_CYC     8'h03
`define ADCC_CONV_CYC     8'h0a
`define ADCC_WAKE_CYC     8'h08

`endif

// ==== hw/adcc_ctrl.sv ====
// Conversion controller: register file, sequencer, results and flags.
// Assumes a synchronous analog cell that answers a sample pulse with done.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl
    import adcc_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic [6:0]        addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [31:0]       rdata,
    input  wire logic              external_trigger_pin,
    input  wire logic [2:0]        timer_trig,
    output adcc_cell_ctl_type      cell_ctl,
    input  wire adcc_cell_res_type cell_res,
    output logic                   dma_req
);
    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [31:0] mode_r;
    logic [11:0] chan_en_r;
    logic [3:0]  trig_sel_r;
    logic [1:0]  cmp_mode_r;
    logic [9:0]  cmp_lo_r, cmp_hi_r;
    logic [11:0] eoc_r, ovr_r;
    logic        data_ready_flag_r, govr_r, cmp_r;
    logic [9:0]  last_r;
    logic [3:0]  last_ch_r;
    logic        rd_r;
    logic        rd_cdat_r;
    logic [31:0] rreg_r;

    wire         low_resolution_bit = mode_r[`ADCC_MODE_LOW_RESOLUTION_BIT];
    wire         sleep_bit          = mode_r[`ADCC_MODE_SLEEP];
    wire [7:0]   clock_divider_field = mode_r[`ADCC_MODE_PRE_LSB +: 8];
    wire [3:0]   tracking_time_field = mode_r[`ADCC_MODE_TRK_LSB +: 4];

    function automatic logic hit(input logic [6:0] a, input logic [6:0] o);
        return a == o;
    endfunction

    wire w_ctrl  = wr && hit(addr, `ADCC_OFS_CTRL);
    wire w_mode  = wr && hit(addr, `ADCC_OFS_MODE);
    wire w_chen  = wr && hit(addr, `ADCC_OFS_CHEN);
    wire w_chdis = wr && hit(addr, `ADCC_OFS_CHDIS);
    wire w_trig  = wr && hit(addr, `ADCC_OFS_TRIG);
    wire w_ext   = wr && hit(addr, `ADCC_OFS_EXT);
    wire w_cwin  = wr && hit(addr, `ADCC_OFS_CWIN);
    wire r_last  = rd && hit(addr, `ADCC_OFS_LAST);
    wire r_stat  = rd && hit(addr, `ADCC_OFS_STAT);
    wire r_ovr   = rd && hit(addr, `ADCC_OFS_OVR);
    wire [4:0] cdat_idx = addr[6:2] - 5'h0c;
    wire r_cdat  = rd && addr[1:0] == 2'b00 && addr[6:2] >= 5'h0c
                   && cdat_idx < 5'h0c;
    wire [3:0] r_ch = cdat_idx[3:0];
    wire soft_rst = w_ctrl && wdata[`ADCC_CTRL_RESET];
    wire soft_start = w_ctrl && wdata[`ADCC_CTRL_START];

    // Writes only store configuration; they never need the converter
    // clock to be running.
    always_ff @(posedge mclk) begin
        if (rst || soft_rst) begin
            mode_r     <= `ADCC_MODE_RST;
            chan_en_r  <= 12'h000;
            trig_sel_r <= 4'h0;
            cmp_mode_r <= 2'h0;
            cmp_lo_r   <= 10'h000;
            cmp_hi_r   <= 10'h3ff;
        end else begin
            if (w_mode) mode_r <= wdata;
            if (w_chen || w_chdis)
                chan_en_r <= (chan_en_r | (w_chen ? wdata[11:0] : 12'h000))
                    & ~(w_chdis ? wdata[11:0] : 12'h000);
            if (w_trig) trig_sel_r <= wdata[3:0];
            if (w_ext) cmp_mode_r <= wdata[1:0];
            if (w_cwin) begin
                cmp_lo_r <= wdata[9:0];
                cmp_hi_r <= wdata[25:16];
            end
        end
    end

    // ------------------------------------------------------------
    // Converter clock enable
    // ------------------------------------------------------------
    logic [8:0] div_r;
    wire [8:0]  div_top = {clock_divider_field, 1'b1};
    wire        cclk_en = div_r == div_top;

    always_ff @(posedge mclk) begin
        if (rst || div_r >= div_top) div_r <= 9'h000;
        else div_r <= div_r + 9'h001;
    end

    // ------------------------------------------------------------
    // Triggers
    // ------------------------------------------------------------
    logic pin_d_r;
    logic [2:0] tmr_d_r;
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_d_r <= 1'b0;
            tmr_d_r <= 3'h0;
        end else begin
            pin_d_r <= external_trigger_pin;
            tmr_d_r <= timer_trig;
        end
    end
    wire pin_rise = external_trigger_pin && !pin_d_r;
    wire [2:0] tmr_rise = timer_trig & ~tmr_d_r;
    // Selector codes beyond the three timers shift the mask out to zero.
    wire [2:0] tmr_idx = trig_sel_r[3:1] - 3'h1;
    wire tmr_hit = (tmr_rise & (3'h1 << tmr_idx)) != 3'h0;
    wire hw_trig = trig_sel_r[0] && (trig_sel_r[3:1] == 3'h0 ? pin_rise
                   : tmr_hit);
    wire trigger = soft_start || hw_trig;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    adcc_state_type state_r, state_nxt;
    logic [3:0]  ch_r;
    logic [7:0]  cnt_r;
    logic [11:0] pend_r;
    logic        store;
    logic [9:0]  res_v;

    function automatic logic [3:0] first_ch(input logic [11:0] m);
        first_ch = 4'hf;
        for (int i = 11; i >= 0; i--)
            if (m[i]) first_ch = i[3:0];
    endfunction

    wire [3:0] nxt_ch  = first_ch(pend_r & ~(12'h001 << ch_r));
    wire       more    = (pend_r & ~(12'h001 << ch_r)) != 12'h000;
    wire [7:0] trk_cyc = {4'h0, tracking_time_field} + 8'h01;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ADCC_IDLE:
                if (trigger && chan_en_r != 12'h000)
                    state_nxt = sleep_bit ? ADCC_WAKE : ADCC_TRACK;
            ADCC_WAKE:
                if (cclk_en && cnt_r == `ADCC_WAKE_CYC) state_nxt = ADCC_TRACK;
            ADCC_TRACK:
                if (cclk_en && cnt_r == trk_cyc) state_nxt = ADCC_CONV;
            ADCC_CONV:
                // Full length always, whatever the resolution.
                if (cclk_en && cnt_r == `ADCC_CONV_CYC)
                    state_nxt = ADCC_NEXT;
            ADCC_NEXT:
                state_nxt = more ? ADCC_TRACK : ADCC_IDLE;
            default:
                state_nxt = ADCC_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst || soft_rst) begin
            state_r <= ADCC_IDLE;
            ch_r    <= 4'h0;
            cnt_r   <= 8'h00;
            pend_r  <= 12'h000;
        end else begin
            state_r <= state_nxt;
            if (state_nxt != state_r) cnt_r <= 8'h00;
            else if (cclk_en) cnt_r <= cnt_r + 8'h01;
            if (state_r == ADCC_IDLE && state_nxt != ADCC_IDLE) begin
                pend_r <= chan_en_r;
                ch_r   <= first_ch(chan_en_r);
            end else if (state_r == ADCC_NEXT) begin
                pend_r <= pend_r & ~(12'h001 << ch_r);
                if (more) ch_r <= nxt_ch;
            end
        end
    end

    // Selection stays put through the hold window after the start.
    assign cell_ctl.chan   = (state_r == ADCC_IDLE || state_r == ADCC_WAKE)
                             ? 12'h000 : (12'h001 << ch_r);
    assign cell_ctl.sample = state_r == ADCC_CONV && cnt_r == 8'h00
                             && cclk_en;
    assign cell_ctl.power  = !sleep_bit || state_r != ADCC_IDLE;
    wire hold_done = state_r != ADCC_CONV || cnt_r >= `ADCC_HOLD_CYC;

    // ------------------------------------------------------------
    // Results and flags
    // ------------------------------------------------------------
    assign store = cell_res.done && state_r == ADCC_CONV;
    assign res_v = low_resolution_bit ? {2'b00, cell_res.data[9:2]}
                                      : cell_res.data;
    wire [9:0] cmp_v = low_resolution_bit ? {cell_res.data[9:2], 2'b00}
                                          : cell_res.data;
    wire lo_hit = cmp_v < cmp_lo_r;
    wire hi_hit = cmp_v > cmp_hi_r;
    wire cmp_hit = cmp_mode_r == 2'h0 ? lo_hit
                 : cmp_mode_r == 2'h1 ? hi_hit
                 : cmp_mode_r == 2'h2 ? !lo_hit && !hi_hit
                 : lo_hit || hi_hit;

    wire [11:0] ch_bit = 12'h001 << ch_r;
    wire [11:0] cdr_clr = r_cdat ? (12'h001 << r_ch) : 12'h000;

    // Sets win over read clears throughout.
    always_ff @(posedge mclk) begin
        if (rst || soft_rst) begin
            eoc_r     <= 12'h000;
            ovr_r     <= 12'h000;
            data_ready_flag_r    <= 1'b0;
            govr_r    <= 1'b0;
            cmp_r     <= 1'b0;
            last_r    <= 10'h000;
            last_ch_r <= 4'h0;
        end else begin
            eoc_r <= (eoc_r & ~cdr_clr) | (store ? ch_bit : 12'h000);
            ovr_r <= (r_ovr ? 12'h000 : ovr_r)
                     | (store ? (ch_bit & eoc_r) : 12'h000);
            data_ready_flag_r <= store || (data_ready_flag_r && !r_last);
            govr_r <= (store && data_ready_flag_r) || (govr_r && !r_stat);
            cmp_r  <= (store && cmp_hit) || (cmp_r && !r_stat);
            if (store) begin
                last_r    <= res_v;
                last_ch_r <= ch_r;
            end
        end
    end

    logic data_ready_flag_d_r;
    always_ff @(posedge mclk) begin
        if (rst) data_ready_flag_d_r <= 1'b0;
        else data_ready_flag_d_r <= data_ready_flag_r;
    end
    assign dma_req = data_ready_flag_r && !data_ready_flag_d_r;

    logic [9:0] mem_q;
    adcc_result_mem u_mem (
        .mclk    (mclk),
        .we      (store),
        .waddr   (ch_r),
        .wdata   (res_v),
        .raddr   (r_ch),
        .rdata_r (mem_q)
    );

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire [31:0] rsel =
        hit(addr, `ADCC_OFS_MODE)   ? mode_r :
        hit(addr, `ADCC_OFS_CHSTAT) ? {20'h0, chan_en_r} :
        hit(addr, `ADCC_OFS_TRIG)   ? {28'h0, trig_sel_r} :
        hit(addr, `ADCC_OFS_LAST)   ? {18'h0, last_ch_r, 10'h0 | last_r} :
        hit(addr, `ADCC_OFS_STAT)   ? {5'h0, cmp_r, govr_r, data_ready_flag_r,
                                       12'h0, eoc_r} :
        hit(addr, `ADCC_OFS_OVR)    ? {20'h0, ovr_r} :
        hit(addr, `ADCC_OFS_EXT)    ? {30'h0, cmp_mode_r} :
        hit(addr, `ADCC_OFS_CWIN)   ? {6'h0, cmp_hi_r, 6'h0, cmp_lo_r} :
        32'h0000_0000;

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_r      <= 1'b0;
            rreg_r    <= 32'h0000_0000;
            rd_cdat_r <= 1'b0;
        end else begin
            rd_r      <= rd;
            rd_cdat_r <= r_cdat;
            rreg_r    <= rd ? rsel : 32'h0000_0000;
        end
    end
    // Only a decoded channel read takes the memory word; holes read zero.
    wire cdat_was = rd_cdat_r;
    assign rdata = !rd_r ? 32'h0000_0000
                 : cdat_was ? {22'h0, mem_q} : rreg_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_data_ready_flag_set;
        @(posedge mclk) disable iff (rst) store |=> data_ready_flag_r;
    endproperty
    a_data_ready_flag_set: assert property (p_data_ready_flag_set) else $error("ready not set");

    property p_low_resolution_bit_zero;
        @(posedge mclk) disable iff (rst)
            store && low_resolution_bit |=> last_r[9:8] == 2'b00;
    endproperty
    a_low_resolution_bit_zero: assert property (p_low_resolution_bit_zero) else $error("upper bits set");

    property p_ignore;
        @(posedge mclk) disable iff (rst)
            state_r != ADCC_IDLE && state_r != ADCC_NEXT && !soft_rst
            |=> state_r != ADCC_IDLE;
    endproperty
    a_ignore: assert property (p_ignore) else $error("sequence cut");

    property p_hold;
        @(posedge mclk) disable iff (rst)
            state_r == ADCC_CONV && !hold_done |=> $stable(cell_ctl.chan);
    endproperty
    a_hold: assert property (p_hold) else $error("selection moved");

    property p_onehot;
        @(posedge mclk) disable iff (rst)
            state_r == ADCC_CONV |-> $onehot(cell_ctl.chan);
    endproperty
    a_onehot: assert property (p_onehot) else $error("not one channel");

    property p_govr;
        @(posedge mclk) disable iff (rst) store && data_ready_flag_r |=> govr_r;
    endproperty
    a_govr: assert property (p_govr) else $error("overrun missed");

    property p_data_ready_flag_clr;
        @(posedge mclk) disable iff (rst)
            r_last && !store |=> !data_ready_flag_r;
    endproperty
    a_data_ready_flag_clr: assert property (p_data_ready_flag_clr) else $error("ready stuck");

    property p_dma;
        @(posedge mclk) disable iff (rst) store && !data_ready_flag_r |=> dma_req;
    endproperty
    a_dma: assert property (p_dma) else $error("no request");
endmodule // adcc_ctrl
`default_nettype wire

// ==== hw/adcc_pkg.sv ====
// Types shared by the conversion controller modules.
// Assumes the constants header is on the include path.
package adcc_pkg;
    `include "adcc_consts.svh"

    typedef enum logic [2:0] {
        ADCC_IDLE  = 3'b000,
        ADCC_WAKE  = 3'b100,
        ADCC_TRACK = 3'b001,
        ADCC_CONV  = 3'b011,
        ADCC_NEXT  = 3'b010
    } adcc_state_type;

    typedef struct packed {
        logic [11:0] chan;
        logic        sample;
        logic        power;
    } adcc_cell_ctl_type;

    typedef struct packed {
        logic        done;
        logic [9:0]  data;
    } adcc_cell_res_type;
endpackage

// ==== hw/adcc_result_mem.sv ====
// Per-channel result store, twelve words of ten bits.
// Assumes a single clock; read data come out of a register.
`timescale 1ns/1ps
`default_nettype none
module adcc_result_mem (
    input  wire logic       mclk,
    input  wire logic       we,
    input  wire logic [3:0] waddr,
    input  wire logic [9:0] wdata,
    input  wire logic [3:0] raddr,
    output logic      [9:0] rdata_r
);
    logic [9:0] mem [0:11];

    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_r <= (raddr < 4'hc) ? mem[raddr] : 10'h000;
    end
endmodule // adcc_result_mem
`default_nettype wire

// ==== verif/adc_conversion_controller_tb.sv ====
// Self-checking bench for the conversion controller.
// Assumes the analog cell model and the design files compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    mismatches++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module adc_conversion_controller_tb
    import adcc_pkg::*;
;
    logic              mclk, rst, wr, rd, ext, dma_req;
    logic [6:0]        addr;
    logic [31:0]       wdata, rdata;
    logic [2:0]        tt;
    logic [7:0]        lat;
    logic [9:0]        vals [12];
    adcc_cell_ctl_type cell_ctl;
    adcc_cell_res_type cell_res;
    int                mismatches, tests_run, cyc, samp_at, chg_at;
    int                samp_cnt, done_cnt, dma_cnt, cur_p, cur_t;
    logic [11:0]       cur_m, chan_q, last_ch;

    adcc_ctrl i_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .external_trigger_pin(ext),
        .timer_trig(tt), .cell_ctl(cell_ctl), .cell_res(cell_res),
        .dma_req(dma_req));
    adcc_cell_model i_cell (.mclk(mclk), .rst(rst), .cell_ctl(cell_ctl),
        .lat(lat), .vals(vals), .cell_res(cell_res));

    // ------------------------------------------------------------------
    // Register bus, results and verdict
    // ------------------------------------------------------------------
    task automatic wreg(input logic [6:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [6:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    function automatic logic [9:0] exp_val(logic [9:0] v, logic lr);
        return lr ? {2'b00, v[9:2]} : v;
    endfunction

    // Thresholds stay at full resolution; low results are scaled up.
    function automatic logic exp_cmp(logic [9:0] v, logic lr, logic [1:0] cm,
                                     logic [9:0] lo, logic [9:0] hi);
        logic [9:0] c;
        logic       below, above;
        c = lr ? {v[9:2], 2'b00} : v;
        below = c < lo;
        above = c > hi;
        case (cm)
            2'h0: return below;
            2'h1: return above;
            2'h2: return !below && !above;
            default: return below || above;
        endcase
    endfunction

    function automatic logic [3:0] hi_ch(logic [11:0] m);
        logic [3:0] h;
        h = 4'h0;
        for (int k = 0; k < 12; k++) begin
            if (m[k]) begin
                h = 4'(k);
            end
        end
        return h;
    endfunction

    task automatic end_sim;
        if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and multiplexer monitor
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    initial begin
        #480000;
        mismatches++;
        end_sim();
    end

    always @(posedge mclk) begin
        cyc++;
        if (!rst) begin
            if (cell_ctl.chan !== chan_q) begin
                if (samp_cnt > 0) `CHK("hold", 1'b1, cyc - samp_at >= 6 * (cur_p + 1))
                chg_at = cyc;
            end
            if (cell_ctl.sample === 1'b1) begin
                `CHK("select", 1'b1, $onehot(cell_ctl.chan) && !(cell_ctl.chan & ~cur_m))
                `CHK("track", 1'b1, cyc - chg_at >= 2 * (cur_p + 1) * (cur_t + 2))
                if (samp_cnt > 0) begin
                    `CHK("order", 1'b1, cell_ctl.chan > last_ch)
                    `CHK("trk_max", 1'b1, cyc - chg_at <= 2 * (cur_p + 1) * (cur_t + 3))
                end
                samp_at = cyc;
                samp_cnt++;
                last_ch = cell_ctl.chan;
            end
            if (cell_res.done === 1'b1) done_cnt++;
            if (dma_req === 1'b1) dma_cnt++;
        end
        chan_q = cell_ctl.chan;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin : main
        logic [31:0] d, md;
        logic [11:0] m;
        logic [3:0]  p, t;
        logic        lr, sl, ce;
        logic [9:0]  lo, hi;
        logic [1:0]  cm;
        int          how, n;
        rst = 1'b1; wr = 1'b0; rd = 1'b0; ext = 1'b0; tt = 3'h0;
        addr = 6'h00; wdata = 32'h0; lat = 8'h01; cur_m = 12'h000;
        vals = '{default: 10'h000};
        void'($urandom(10));
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        rreg(`ADCC_OFS_MODE, d);
        `CHK("mode_rst", 32'h0, d)
        rreg(7'h2c, d);
        `CHK("unmapped", 32'h0, d)
        for (int i = 0; i < 8; i++) begin
            m = (i == 0) ? 12'hfff : (i == 1) ? 12'h800 : 12'($urandom) | 12'h001;
            p = (i < 4) ? 4'(i % 2) : 4'($urandom_range(3, 0));
            t = 4'($urandom);
            lr = i[0];
            sl = (i == 3);
            how = i % 5;
            cur_m = m; cur_p = p; cur_t = t; n = $countones(m);
            @(posedge mclk);
            lat <= (i > 3) ? 8'h0c : 8'h01;
            for (int k = 0; k < 12; k++) vals[k] <= (i < 2) ? 10'h3ff : 10'($urandom);
            wreg(`ADCC_OFS_CHDIS, 32'hfff);
            wreg(`ADCC_OFS_CHEN, {20'h0, m});
            rreg(`ADCC_OFS_CHSTAT, d);
            `CHK("chan_en", {20'h0, m}, d)
            md = {4'h0, t, 8'h00, 8'(p), 2'b00, sl, lr, 4'h0};
            wreg(`ADCC_OFS_MODE, md);
            rreg(`ADCC_OFS_MODE, d);
            `CHK("mode", md, d)
            wreg(`ADCC_OFS_TRIG, (how == 0) ? 32'h0 : {28'h0, 3'(how - 1), 1'b1});
            cm = 2'(i);
            lo = 10'($urandom);
            hi = 10'($urandom);
            wreg(`ADCC_OFS_EXT, {30'h0, cm});
            wreg(`ADCC_OFS_CWIN, {6'h0, hi, 6'h0, lo});
            if (sl) begin
                repeat (40) @(posedge mclk);
                #1 `CHK("asleep", 1'b0, cell_ctl.power)
            end
            dma_cnt = 0;
            for (int r = 0; r < ((i == 2) ? 2 : 1); r++) begin
                samp_cnt = 0;
                done_cnt = 0;
                if (how == 0) wreg(`ADCC_OFS_CTRL, 32'h2);
                else begin
                    @(posedge mclk);
                    if (how == 1) ext <= 1'b1;
                    else tt[how - 2] <= 1'b1;
                    repeat (4) @(posedge mclk);
                    ext <= 1'b0;
                    tt  <= 3'h0;
                end
                for (int w = 0; w < 4000 && samp_cnt < 1; w++) @(posedge mclk);
                wreg(`ADCC_OFS_CTRL, 32'h2);
                for (int w = 0; w < 20000 && done_cnt < n; w++) @(posedge mclk);
                repeat (300) @(posedge mclk);
                `CHK("conversions", n, samp_cnt)
                `CHK("dones", n, done_cnt)
            end
            `CHK("dma", 1, dma_cnt)
            if (sl) #1 `CHK("resleep", 1'b0, cell_ctl.power)
            ce = 1'b0;
            for (int k = 0; k < 12; k++) begin
                if (m[k]) begin
                    ce = ce | exp_cmp(vals[k], lr, cm, lo, hi);
                end
            end
            rreg(`ADCC_OFS_STAT, d);
            `CHK("status", {5'h0, ce, (n > 1 || i == 2), 1'b1, 12'h0, m}, d & 32'h07000fff)
            rreg(`ADCC_OFS_OVR, d);
            `CHK("overrun", (i == 2) ? {20'h0, m} : 32'h0, d)
            for (int k = 0; k < 12; k++) begin
                if (m[k]) begin
                    rreg(7'(`ADCC_OFS_CDAT0 + 4 * k), d);
                    `CHK("chan_data", {22'h0, exp_val(vals[k], lr)}, d)
                end
            end
            rreg(`ADCC_OFS_LAST, d);
            `CHK("last", {18'h0, hi_ch(m), exp_val(vals[hi_ch(m)], lr)}, d)
            rreg(`ADCC_OFS_STAT, d);
            `CHK("cleared", 32'h0, d & 32'h07000fff)
            rreg(`ADCC_OFS_OVR, d);
            `CHK("ovr_clr", 32'h0, d)
        end
        // The control reset bit must bring back the reset configuration.
        wreg(`ADCC_OFS_MODE, 32'h0000_0310);
        wreg(`ADCC_OFS_CTRL, 32'h1);
        rreg(`ADCC_OFS_MODE, d);
        `CHK("soft_rst", 32'h0, d)
        rreg(`ADCC_OFS_CHSTAT, d);
        `CHK("chan_rst", 32'h0, d)
        end_sim();
    end
endmodule // adc_conversion_controller_tb
`default_nettype wire

// ==== verif/adcc_cell_model.sv ====
// Behavioural model of the analog cell, multiplexer and converter.
// Assumes a one-hot channel select and a sample pulse from the controller.
`timescale 1ns/1ps
`default_nettype none
module adcc_cell_model
    import adcc_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire adcc_cell_ctl_type cell_ctl,
    input  wire logic [7:0]        lat,
    input  wire logic [9:0]        vals [12],
    output var  adcc_cell_res_type cell_res
);
    logic [7:0] cnt_r;
    logic       busy_r;
    logic [3:0] idx_r;

    // Data toggle outside the done pulse so that stale values never match.
    always_ff @(posedge mclk) begin
        cell_res.done <= 1'b0;
        cell_res.data <= ~cell_res.data;
        if (rst) begin
            busy_r   <= 1'b0;
            cell_res <= '0;
        end else if (busy_r) begin
            if (cnt_r == 8'h00) begin
                busy_r        <= 1'b0;
                cell_res.done <= 1'b1;
                cell_res.data <= vals[idx_r];
            end else begin
                cnt_r <= cnt_r - 8'h01;
            end
        end else if (cell_ctl.sample && cell_ctl.power) begin
            busy_r <= 1'b1;
            cnt_r  <= lat;
            for (int k = 0; k < 12; k++) begin
                if (cell_ctl.chan[k]) begin
                    idx_r <= 4'(k);
                end
            end
        end
    end
endmodule // adcc_cell_model
`default_nettype wire
